// ===== rtl/rbk_bank_ram.sv
// working register ram: lowest internal ram bytes holding all four banks
`timescale 1ns/10ps
module rbk_bank_ram
    import rbk_pkg::*;
(
    input  wire logic CLK_I,
    rbk_ram_if.mem    ram
);
    logic [DW-1:0] mem_q [RAM_DEPTH];
    logic [DW-1:0] next_mem [RAM_DEPTH];

    // next contents per byte
    always_comb begin
        for (int i = 0; i < RAM_DEPTH; i++) begin
            next_mem[i] = mem_q[i];
        end
        if (ram.we) begin
            next_mem[ram.waddr] = ram.wdata;
        end
    end

    // storage, contents undefined after reset
    generate
        for (genvar g = 0; g < RAM_DEPTH; g++) begin : g_byte
            always_ff @(posedge CLK_I) begin
                mem_q[g] <= next_mem[g];
            end
        end
    endgenerate

    // two combinational read ports
    assign ram.rdata = mem_q[ram.raddr];
    assign ram.pdata = mem_q[ram.paddr];
endmodule // rbk_bank_ram

// ===== rtl/rbk_pkg.sv
// package: register bank and special function register constants
package rbk_pkg;
    localparam int               DW            = 8;
    localparam int               AW            = 8;
    localparam int               RAM_DEPTH     = 32;
    localparam int               BANK_COUNT    = 4;
    localparam int               REGS_PER_BANK = 8;
    localparam int               BANK_LSB      = 3;
    localparam int               BANK_MSB      = 4;
    localparam logic [AW-1:0]    SFR_BASE      = 8'h80;
    localparam logic [DW-1:0]    PORT_RESET    = 8'hff;
    localparam logic [DW-1:0]    ZERO_RESET    = 8'h00;
    localparam logic [DW-1:0]    SP_RESET      = 8'h07;
    localparam logic [DW-1:0]    ONCHIP_XDATA_PAGE_COMPARE_RESET    = 8'hf8;
    localparam logic [DW-1:0]    BAUD_RELOAD_LOW_RESET   = 8'hd9;
    localparam logic [DW-1:0]    POWER_CONTROL_RESET    = 8'h00;
    localparam logic [DW-1:0]    DATA_POINTER_SELECT_RESET   = 8'h00;
    localparam logic [DW-1:0]    IE_RESET      = 8'h00;
    localparam logic [DW-1:0]    SERIAL_BUFFER_RESET    = 8'h00;
    localparam logic [AW-1:0]    A_PORT0       = 8'h80;
    localparam logic [AW-1:0]    A_SP          = 8'h81;
    localparam logic [AW-1:0]    A_DPL         = 8'h82;
    localparam logic [AW-1:0]    A_DPH         = 8'h83;
    localparam logic [AW-1:0]    A_WATCHDOG_RELOAD      = 8'h86;
    localparam logic [AW-1:0]    A_POWER_CONTROL        = 8'h87;
    localparam logic [AW-1:0]    A_TIMER_CONTROL        = 8'h88;
    localparam logic [AW-1:0]    A_TIMER_MODE        = 8'h89;
    localparam logic [AW-1:0]    A_TL0         = 8'h8a;
    localparam logic [AW-1:0]    A_TL1         = 8'h8b;
    localparam logic [AW-1:0]    A_TH0         = 8'h8c;
    localparam logic [AW-1:0]    A_TH1         = 8'h8d;
    localparam logic [AW-1:0]    A_PORT1       = 8'h90;
    localparam logic [AW-1:0]    A_EXTERNAL_PAGE_ADDRESS       = 8'h91;
    localparam logic [AW-1:0]    A_DATA_POINTER_SELECT       = 8'h92;
    localparam logic [AW-1:0]    A_ONCHIP_XDATA_PAGE_COMPARE        = 8'h94;
    localparam logic [AW-1:0]    A_SERIAL_CONTROL        = 8'h98;
    localparam logic [AW-1:0]    A_SERIAL_BUFFER        = 8'h99;
    localparam logic [AW-1:0]    A_PORT2       = 8'ha0;
    localparam logic [AW-1:0]    A_IE          = 8'ha8;
    localparam logic [AW-1:0]    A_BAUD_RELOAD_LOW       = 8'haa;
    localparam logic [AW-1:0]    A_PSW         = 8'hd0;
    localparam int               SFR_COUNT     = 22;
    localparam logic [7:0]       BIT_SFR_MASK  = 8'h07;
    localparam logic [2:0]       OPC_REG_LSB   = 3'h0;
    typedef enum logic [1:0] {
        RBK_IDLE  = 2'b00,
        RBK_PUSH  = 2'b01,
        RBK_POP   = 2'b11
    } rbk_stk_t;
endpackage

// ===== rtl/rbk_ram_if.sv
// interface: internal data ram access between the core logic and the ram
`timescale 1ns/10ps
interface rbk_ram_if;
    logic       we;
    logic [4:0] waddr;
    logic [7:0] wdata;
    logic [4:0] raddr;
    logic [7:0] rdata;
    logic [4:0] paddr;
    logic [7:0] pdata;
    modport core (output we, waddr, wdata, raddr, paddr, input rdata, pdata);
    modport mem  (input we, waddr, wdata, raddr, paddr, output rdata, pdata);
endinterface

// ===== rtl/rbk_regfile.sv
// register banks and lower special function register map
`timescale 1ns/10ps
// Overview of operation
// - lowest 32 ram bytes are four banks of eight working registers
// - only one bank active; register writes and pointers reach only that bank, register reads only while RAM_ADDR_I is 20 hex or more
// - status word bits 3 and 4 give the bank number, switching at once
// - opcode register field picks one of eight registers of active bank
// - only registers zero and one serve as indirect pointers
// - reset loads the stack pointer with 07 hex
// - stack pointer increments before a store; first push lands at 08 hex
// - special function area holds all other registers and bit addresses
// - map holds the special function registers reaching peripherals
// - bit-addressable registers support bit set, clear and test
// - reserved addresses read zero and take no writes; undefined bits hold no defined value
module rbk_regfile
    import rbk_pkg::*;
(
    input  wire logic              CLK_I,
    input  wire logic              NRST_I,
    input  wire logic [2:0]        OPC_REG_I,
    input  wire logic              REG_WR_I,
    input  wire logic [DW-1:0]     REG_WDATA_I,
    input  wire logic              PTR_SEL_I,
    input  wire logic              RAM_WR_I,
    input  wire logic [AW-1:0]     RAM_ADDR_I,
    input  wire logic [DW-1:0]     RAM_WDATA_I,
    input  wire logic              SFR_WR_I,
    input  wire logic              SFR_BIT_WR_I,
    input  wire logic              SFR_BIT_VAL_I,
    input  wire logic [AW-1:0]     SFR_ADDR_I,
    input  wire logic [DW-1:0]     SFR_WDATA_I,
    input  wire logic              PUSH_I,
    input  wire logic              POP_I,
    input  wire logic [DW-1:0]     PUSH_DATA_I,
    output logic      [DW-1:0]     REG_RDATA_O,
    output logic      [DW-1:0]     PTR_O,
    output logic      [DW-1:0]     RAM_RDATA_O,
    output logic      [DW-1:0]     SFR_RDATA_O,
    output logic                   SFR_BIT_O,
    output logic                   SFR_HIT_O,
    output logic      [DW-1:0]     SP_O,
    output logic      [1:0]        BANK_O,
    output logic      [DW-1:0]     PORT0_O,
    output logic      [DW-1:0]     PORT1_O,
    output logic      [DW-1:0]     PORT2_O
);
    import rbk_pkg::*;

    rbk_ram_if ram ();

    // sfr storage, indexed by map entry
    logic [DW-1:0] sfr      [SFR_COUNT];
    logic [DW-1:0] next_sfr [SFR_COUNT];
    logic [DW-1:0] program_status_word, next_program_status_word;
    logic [DW-1:0] stack_pointer, next_stack_pointer;
    rbk_stk_t      stk_op;
    logic [AW-1:0] sfr_addr_tab [SFR_COUNT];
    logic [1:0]    bank;
    logic [4:0]    reg_addr;
    logic [4:0]    ptr_addr;
    logic [4:0]    hit_idx;
    logic          hit, hit_psw, hit_sp, bit_ok;
    logic [DW-1:0] cur_byte, bit_new;
    logic          bit_test;
    logic [DW-1:0] next_reg_rdata, next_ptr, next_ram_rdata, next_sfr_rdata;
    logic          next_sfr_bit, next_sfr_hit;

    // map table, status word and stack pointer last; their values are kept separately
    assign sfr_addr_tab = '{A_PORT0, A_DPL, A_DPH, A_WATCHDOG_RELOAD, A_POWER_CONTROL, A_TIMER_CONTROL, A_TIMER_MODE,
                            A_TL0, A_TL1, A_TH0, A_TH1, A_PORT1, A_EXTERNAL_PAGE_ADDRESS, A_DATA_POINTER_SELECT,
                            A_ONCHIP_XDATA_PAGE_COMPARE, A_SERIAL_CONTROL, A_SERIAL_BUFFER, A_PORT2, A_IE, A_BAUD_RELOAD_LOW,
                            A_PSW, A_SP};
    // reset contents as constants, so the async reset branch loads no logic
    localparam logic [DW-1:0] RST_TAB [SFR_COUNT] = '{PORT_RESET, ZERO_RESET, ZERO_RESET,
                            ZERO_RESET, POWER_CONTROL_RESET,
                            ZERO_RESET, ZERO_RESET, ZERO_RESET, ZERO_RESET, ZERO_RESET,
                            ZERO_RESET, PORT_RESET, ZERO_RESET, DATA_POINTER_SELECT_RESET, ONCHIP_XDATA_PAGE_COMPARE_RESET,
                            ZERO_RESET, SERIAL_BUFFER_RESET, PORT_RESET, IE_RESET, BAUD_RELOAD_LOW_RESET,
                            ZERO_RESET, SP_RESET};

    // active bank from status word bits, used at once
    assign bank     = program_status_word[BANK_MSB:BANK_LSB];
    assign reg_addr = {bank, OPC_REG_I};
    assign ptr_addr = {bank, 2'b00, PTR_SEL_I};

    // sfr address decode over the map table
    always_comb begin
        hit     = 1'b0;
        hit_idx = 5'h00;
        for (int i = 0; i < SFR_COUNT; i++) begin
            if (sfr_addr_tab[i] == SFR_ADDR_I) begin
                hit     = 1'b1;
                hit_idx = 5'(i);
            end
        end
        hit_psw  = (SFR_ADDR_I == A_PSW);
        hit_sp   = (SFR_ADDR_I == A_SP);
        bit_ok   = hit && ((SFR_ADDR_I & BIT_SFR_MASK) == 8'h00);
        cur_byte = hit_psw ? program_status_word :
                   hit_sp  ? stack_pointer : (hit ? sfr[hit_idx] : 8'h00);
    end

    // bit field replacement for bit operations
    rbk_sfr_bits u_bits (
        .old_i  (cur_byte),
        .bit_i  (OPC_REG_I),
        .val_i  (SFR_BIT_VAL_I),
        .new_o  (bit_new),
        .test_o (bit_test)
    );

    // stack operation select
    always_comb begin
        stk_op = RBK_IDLE;
        if (PUSH_I) begin
            stk_op = RBK_PUSH;
        end else if (POP_I) begin
            stk_op = RBK_POP;
        end
    end

    // next sfr, status word and stack pointer values
    always_comb begin
        for (int i = 0; i < SFR_COUNT; i++) begin
            next_sfr[i] = sfr[i];
        end
        next_program_status_word = program_status_word;
        next_stack_pointer       = stack_pointer;
        if (hit && SFR_WR_I) begin
            next_sfr[hit_idx] = SFR_WDATA_I;
        end else if (bit_ok && SFR_BIT_WR_I) begin
            next_sfr[hit_idx] = bit_new;
        end
        if (hit_psw && (SFR_WR_I || (bit_ok && SFR_BIT_WR_I))) begin
            next_program_status_word = SFR_WR_I ? SFR_WDATA_I : bit_new;
        end
        if (hit_sp && SFR_WR_I) begin
            next_stack_pointer = SFR_WDATA_I;
        end
        case (stk_op)
            RBK_PUSH: next_stack_pointer = stack_pointer + 8'h01;
            RBK_POP:  next_stack_pointer = stack_pointer - 8'h01;
            RBK_IDLE: next_stack_pointer = next_stack_pointer;
            default:  next_stack_pointer = next_stack_pointer;
        endcase
    end

    // register map state
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            program_status_word <= ZERO_RESET;
            stack_pointer       <= SP_RESET;
        end else begin
            program_status_word <= next_program_status_word;
            stack_pointer       <= next_stack_pointer;
        end
    end

    generate
        for (genvar g = 0; g < SFR_COUNT; g++) begin : g_sfr
            always_ff @(posedge CLK_I or negedge NRST_I) begin
                if (!NRST_I) begin
                    sfr[g] <= RST_TAB[g];
                end else begin
                    sfr[g] <= next_sfr[g];
                end
            end
        end
    endgenerate

    // ram port steering: push beats register write beats plain write
    always_comb begin
        ram.we    = 1'b0;
        ram.waddr = reg_addr;
        ram.wdata = REG_WDATA_I;
        if (stk_op == RBK_PUSH && next_stack_pointer < 8'(RAM_DEPTH)) begin
            ram.we    = 1'b1;
            ram.waddr = next_stack_pointer[4:0];
            ram.wdata = PUSH_DATA_I;
        end else if (REG_WR_I) begin
            ram.we    = 1'b1;
        end else if (RAM_WR_I && RAM_ADDR_I < 8'(RAM_DEPTH)) begin
            ram.we    = 1'b1;
            ram.waddr = RAM_ADDR_I[4:0];
            ram.wdata = RAM_WDATA_I;
        end
        ram.raddr = (RAM_ADDR_I < 8'(RAM_DEPTH)) ? RAM_ADDR_I[4:0] : reg_addr;
        ram.paddr = ptr_addr;
    end

    rbk_bank_ram u_ram (
        .CLK_I (CLK_I),
        .ram   (ram.mem)
    );

    // registered read data; reserved addresses read zero
    always_comb begin
        next_reg_rdata = ram.rdata;
        next_ptr       = ram.pdata;
        next_ram_rdata = ram.rdata;
        next_sfr_rdata = cur_byte;
        next_sfr_bit   = bit_ok ? bit_test : 1'b0;
        next_sfr_hit   = hit;
    end

    // all outputs leave from flip-flops
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            REG_RDATA_O <= ZERO_RESET;
            PTR_O       <= ZERO_RESET;
            RAM_RDATA_O <= ZERO_RESET;
            SFR_RDATA_O <= ZERO_RESET;
            SFR_BIT_O   <= 1'b0;
            SFR_HIT_O   <= 1'b0;
        end else begin
            REG_RDATA_O <= next_reg_rdata;
            PTR_O       <= next_ptr;
            RAM_RDATA_O <= next_ram_rdata;
            SFR_RDATA_O <= next_sfr_rdata;
            SFR_BIT_O   <= next_sfr_bit;
            SFR_HIT_O   <= next_sfr_hit;
        end
    end

    // mirrors of state, registered copies
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            SP_O    <= SP_RESET;
            BANK_O  <= 2'h0;
            PORT0_O <= PORT_RESET;
            PORT1_O <= PORT_RESET;
            PORT2_O <= PORT_RESET;
        end else begin
            SP_O    <= next_stack_pointer;
            BANK_O  <= next_program_status_word[BANK_MSB:BANK_LSB];
            PORT0_O <= next_sfr[0];
            PORT1_O <= next_sfr[11];
            PORT2_O <= next_sfr[17];
        end
    end

    // checks
    property p_sp_reset;
        @(posedge CLK_I) $rose(NRST_I) |-> SP_O == SP_RESET;
    endproperty
    a_sp_reset: assert property (p_sp_reset) else $error("sp not 07 after reset");

    property p_push_inc;
        @(posedge CLK_I) disable iff (!NRST_I)
            PUSH_I && !(hit_sp && SFR_WR_I) |=> SP_O == $past(stack_pointer) + 8'h01;
    endproperty
    a_push_inc: assert property (p_push_inc) else $error("push did not pre-increment");

    property p_bank_follow;
        @(posedge CLK_I) disable iff (!NRST_I)
            hit_psw && SFR_WR_I |=> BANK_O == $past(SFR_WDATA_I[4:3]);
    endproperty
    a_bank_follow: assert property (p_bank_follow) else $error("bank not switched");

    property p_reg_addr;
        @(posedge CLK_I) disable iff (!NRST_I)
            reg_addr == {bank, 3'b000} + {2'b00, OPC_REG_I};
    endproperty
    a_reg_addr: assert property (p_reg_addr) else $error("register address wrong");

    property p_reg_in_bank;
        @(posedge CLK_I) disable iff (!NRST_I)
            REG_WR_I && !PUSH_I |-> ram.waddr[4:3] == bank;
    endproperty
    a_reg_in_bank: assert property (p_reg_in_bank) else $error("write left active bank");

    property p_ptr_low;
        @(posedge CLK_I) disable iff (!NRST_I) ptr_addr[2:1] == 2'b00;
    endproperty
    a_ptr_low: assert property (p_ptr_low) else $error("pointer not reg 0 or 1");

    property p_bit_set;
        @(posedge CLK_I) disable iff (!NRST_I)
            bit_ok && SFR_BIT_WR_I && !SFR_WR_I && !hit_psw && SFR_ADDR_I == A_PORT1
            |=> PORT1_O[$past(OPC_REG_I)] == $past(SFR_BIT_VAL_I);
    endproperty
    a_bit_set: assert property (p_bit_set) else $error("bit write failed");

    property p_first_push;
        @(posedge CLK_I) disable iff (!NRST_I)
            PUSH_I && stack_pointer == SP_RESET |-> ram.we && ram.waddr == 5'h08;
    endproperty
    a_first_push: assert property (p_first_push) else $error("first push not at 08");

    c_push:    cover property (@(posedge CLK_I) disable iff (!NRST_I) PUSH_I);
    c_bank3:   cover property (@(posedge CLK_I) disable iff (!NRST_I) BANK_O == 2'h3);
    c_bit_wr:  cover property (@(posedge CLK_I) disable iff (!NRST_I) bit_ok && SFR_BIT_WR_I);
endmodule // rbk_regfile

// ===== rtl/rbk_sfr_bits.sv
// bit operation helper: set, clear or replace one bit of a byte
`timescale 1ns/10ps
module rbk_sfr_bits
    import rbk_pkg::*;
(
    input  wire logic [DW-1:0] old_i,
    input  wire logic [2:0]    bit_i,
    input  wire logic          val_i,
    output logic [DW-1:0]      new_o,
    output logic               test_o
);
    // one bit replaced, others kept
    always_comb begin
        new_o         = old_i;
        new_o[bit_i]  = val_i;
        test_o        = old_i[bit_i];
    end
endmodule // rbk_sfr_bits

// ===== tb/rbk_core_model.sv
// partner model: processor core driving the register file request ports
`timescale 1ns/10ps
module rbk_core_model (
    input  wire logic                clk_i,
    output logic [2:0]               opc_reg_o,
    output logic                     reg_wr_o,
    output logic [rbk_pkg::DW-1:0]   reg_wdata_o,
    output logic                     ptr_sel_o,
    output logic                     ram_wr_o,
    output logic [rbk_pkg::AW-1:0]   ram_addr_o,
    output logic [rbk_pkg::DW-1:0]   ram_wdata_o,
    output logic                     sfr_wr_o,
    output logic                     sfr_bit_wr_o,
    output logic                     sfr_bit_val_o,
    output logic [rbk_pkg::AW-1:0]   sfr_addr_o,
    output logic [rbk_pkg::DW-1:0]   sfr_wdata_o,
    output logic                     push_o,
    output logic                     pop_o,
    output logic [rbk_pkg::DW-1:0]   push_data_o
);
    import rbk_pkg::*;
    // quiet bus at time zero
    initial begin
        {opc_reg_o, reg_wdata_o, ptr_sel_o, ram_addr_o, ram_wdata_o} = '0;
        {sfr_bit_val_o, sfr_addr_o, sfr_wdata_o, push_data_o} = '0;
        hold();
    end
    // drop every strobe, keep addresses so reads stay selected
    task hold();
        {reg_wr_o, ram_wr_o, sfr_wr_o, sfr_bit_wr_o, push_o, pop_o} = '0;
    endtask
    // one request each, launched at the falling edge
    task sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        {reg_wr_o, ram_wr_o, sfr_wr_o, sfr_bit_wr_o, push_o, pop_o} = 6'b001000;
        sfr_addr_o = a;
        sfr_wdata_o = d;
    endtask
    task sfr_bit(input logic [7:0] a, input logic [2:0] k, input logic v);
        @(negedge clk_i);
        {reg_wr_o, ram_wr_o, sfr_wr_o, sfr_bit_wr_o, push_o, pop_o} = 6'b000100;
        sfr_addr_o = a;
        opc_reg_o = k;
        sfr_bit_val_o = v;
    endtask
    task sfr_sel(input logic [7:0] a);
        @(negedge clk_i); hold(); sfr_addr_o = a;
    endtask
    task reg_wr(input logic [2:0] r, input logic [7:0] d);
        @(negedge clk_i);
        {reg_wr_o, ram_wr_o, sfr_wr_o, sfr_bit_wr_o, push_o, pop_o} = 6'b100000;
        opc_reg_o = r;
        reg_wdata_o = d;
    endtask
    task ram_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        {reg_wr_o, ram_wr_o, sfr_wr_o, sfr_bit_wr_o, push_o, pop_o} = 6'b010000;
        ram_addr_o = a;
        ram_wdata_o = d;
    endtask
    task ram_sel(input logic [7:0] a, input logic [2:0] r, input logic p);
        @(negedge clk_i); hold(); ram_addr_o = a; opc_reg_o = r; ptr_sel_o = p;
    endtask
    task push(input logic [7:0] d);
        @(negedge clk_i);
        {reg_wr_o, ram_wr_o, sfr_wr_o, sfr_bit_wr_o, push_o, pop_o} = 6'b000010;
        push_data_o = d;
    endtask
    task pop();
        @(negedge clk_i);
        {reg_wr_o, ram_wr_o, sfr_wr_o, sfr_bit_wr_o, push_o, pop_o} = 6'b000001;
    endtask
endmodule // rbk_core_model

// ===== tb/register_banks_and_sfr_map_tb.sv
// testbench: register banks, stack pointer and special function map
`timescale 1ns/10ps
module register_banks_and_sfr_map_tb;
    import rbk_pkg::*;
    typedef struct { int sel; logic [7:0] exp; } rbk_note_t;
    localparam int S_SFR = 0, S_BIT = 1, S_HIT = 2, S_RAM = 3, S_REG = 4, S_PTR = 5;
    localparam int S_SP = 6, S_BANK = 7, S_P0 = 8, S_P1 = 9, S_P2 = 10;
    logic clk = 1'b0, nrst = 1'b0, ptr_sel, ram_wr, reg_wr, sfr_wr, sfr_bwr, sfr_bval;
    logic push, pop, sfr_bit, sfr_hit;
    logic [2:0] opc;
    logic [1:0] bank;
    logic [7:0] reg_wd, ram_a, ram_wd, sfr_a, sfr_wd, push_d, reg_rd, ptr, ram_rd, sfr_rd;
    logic [7:0] sp, p0, p1, p2, got;
    logic [31:0] seed = 32'h26db;
    int miscompares = 0, num_checks = 0, cycles = 0;
    rbk_note_t notes[$];
    rbk_note_t n;
    event note_ev;
    // lower map in address order, with reset contents
    logic [7:0] map_a [22] = '{A_PORT0, A_SP, A_DPL, A_DPH, A_WATCHDOG_RELOAD, A_POWER_CONTROL, A_TIMER_CONTROL,
        A_TIMER_MODE, A_TL0, A_TL1, A_TH0, A_TH1, A_PORT1, A_EXTERNAL_PAGE_ADDRESS, A_DATA_POINTER_SELECT, A_ONCHIP_XDATA_PAGE_COMPARE, A_SERIAL_CONTROL,
        A_SERIAL_BUFFER, A_PORT2, A_IE, A_BAUD_RELOAD_LOW, A_PSW};
    logic [7:0] map_r [22] = '{8'hff, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'hf8, 8'h00, 8'h00, 8'hff,
        8'h00, 8'hd9, 8'h00};
    logic [21:0] mixed = 22'h0a4020; // registers with undefined bits
    logic [7:0] mem [32];
    logic [7:0] wv [22];

    always #2.5 clk = ~clk;

    rbk_core_model i_core (.clk_i(clk), .opc_reg_o(opc), .reg_wr_o(reg_wr),
        .reg_wdata_o(reg_wd), .ptr_sel_o(ptr_sel), .ram_wr_o(ram_wr), .ram_addr_o(ram_a),
        .ram_wdata_o(ram_wd), .sfr_wr_o(sfr_wr), .sfr_bit_wr_o(sfr_bwr),
        .sfr_bit_val_o(sfr_bval), .sfr_addr_o(sfr_a), .sfr_wdata_o(sfr_wd),
        .push_o(push), .pop_o(pop), .push_data_o(push_d));

    rbk_regfile i_dut (.CLK_I(clk), .NRST_I(nrst), .OPC_REG_I(opc), .REG_WR_I(reg_wr),
        .REG_WDATA_I(reg_wd), .PTR_SEL_I(ptr_sel), .RAM_WR_I(ram_wr), .RAM_ADDR_I(ram_a),
        .RAM_WDATA_I(ram_wd), .SFR_WR_I(sfr_wr), .SFR_BIT_WR_I(sfr_bwr),
        .SFR_BIT_VAL_I(sfr_bval), .SFR_ADDR_I(sfr_a), .SFR_WDATA_I(sfr_wd),
        .PUSH_I(push), .POP_I(pop), .PUSH_DATA_I(push_d), .REG_RDATA_O(reg_rd),
        .PTR_O(ptr), .RAM_RDATA_O(ram_rd), .SFR_RDATA_O(sfr_rd), .SFR_BIT_O(sfr_bit),
        .SFR_HIT_O(sfr_hit), .SP_O(sp), .BANK_O(bank), .PORT0_O(p0), .PORT1_O(p1),
        .PORT2_O(p2));

    // xorshift source for data values
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // one cycle on, all strobes dropped
    task step();
        @(negedge clk);
        i_core.hold();
    endtask
    // record an expected result for the watcher
    task note(input int sel, input logic [7:0] exp);
        notes.push_back('{sel, exp});
        -> note_ev;
    endtask
    task cmp(input logic [7:0] g, input logic [7:0] e, input int sel);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t kind %0d got %h expected %h", $time, sel, g, e);
        end
    endtask
    task results();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // watcher: compares settled outputs against the oldest notes
    always @(note_ev) begin
        while (notes.size() > 0) begin
            n = notes.pop_front();
            case (n.sel)
                S_SFR:   got = sfr_rd;
                S_BIT:   got = {7'h00, sfr_bit};
                S_HIT:   got = {7'h00, sfr_hit};
                S_RAM:   got = ram_rd;
                S_REG:   got = reg_rd;
                S_PTR:   got = ptr;
                S_SP:    got = sp;
                S_BANK:  got = {6'h00, bank};
                S_P0:    got = p0;
                S_P1:    got = p1;
                default: got = p2;
            endcase
            cmp(got, n.exp, n.sel);
        end
    end

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            $display("MISMATCH t=%0t timeout", $time);
            results();
        end
    end

    initial begin
        int i, b, r, k;
        logic [7:0] d, pv;
        repeat (5) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        // reset contents of the whole lower map
        note(S_SP, 8'h07);
        note(S_P0, 8'hff);
        note(S_P1, 8'hff);
        note(S_P2, 8'hff);
        note(S_BANK, 8'h00);
        for (i = 0; i < 22; i++) begin
            i_core.sfr_sel(map_a[i]);
            step();
            note(S_SFR, map_r[i]);
            note(S_HIT, 8'h01);
        end
        // stack: pre-increment, first byte at 08, then pop and a back-to-back pair
        d = xs();
        i_core.push(d);
        step();
        note(S_SP, 8'h08);
        i_core.sfr_wr(A_PSW, 8'h08);
        i_core.ram_sel(8'hff, 3'h0, 1'b0);
        step();
        note(S_REG, d);
        i_core.pop();
        step();
        note(S_SP, 8'h07);
        i_core.push(8'h5a);
        i_core.push(8'ha5);
        step();
        note(S_SP, 8'h09);
        i_core.ram_sel(8'h09, 3'h0, 1'b0);
        step();
        note(S_RAM, 8'ha5);
        // fill every register of every bank through register addressing
        for (b = 0; b < 4; b++) begin
            d = xs();
            i_core.sfr_wr(A_PSW, {d[7:5], b[1:0], d[2:0]});
            step();
            note(S_BANK, 8'(b));
            for (r = 0; r < 8; r++) begin
                mem[b * 8 + r] = 8'(xs());
                i_core.reg_wr(r[2:0], mem[b * 8 + r]);
            end
        end
        d = xs();
        i_core.ram_wr(8'h1f, d);
        mem[31] = d;
        i_core.ram_wr(8'h40, ~d);
        for (i = 0; i < 32; i++) begin
            i_core.ram_sel(8'(i), 3'h0, 1'b0);
            step();
            note(S_RAM, mem[i]);
        end
        // each bank shows only its own registers and pointers
        for (b = 3; b >= 0; b--) begin
            i_core.sfr_wr(A_PSW, {3'h0, b[1:0], 3'h0});
            for (r = 0; r < 8; r++) begin
                i_core.ram_sel(8'h20 | 8'(xs()), r[2:0], r[0]);
                step();
                note(S_REG, mem[b * 8 + r]);
                note(S_PTR, mem[b * 8 + r % 2]);
            end
        end
        // byte write and readback, unmapped write refused
        for (i = 0; i < 22; i++) begin
            wv[i] = 8'(xs());
            i_core.sfr_wr(map_a[i], wv[i]);
            i_core.sfr_sel(map_a[i]);
            step();
            if (!mixed[i])
                note(S_SFR, wv[i]);
        end
        note(S_P2, wv[18]);
        i_core.sfr_wr(8'h84, 8'h3c);
        i_core.sfr_sel(8'h84);
        step();
        note(S_HIT, 8'h00);
        note(S_SFR, 8'h00);
        // single-bit set, clear and test on a bit-addressable port
        pv = wv[12];
        for (k = 0; k < 8; k++) begin
            d = xs();
            i_core.sfr_bit(A_PORT1, k[2:0], d[0]);
            pv[k] = d[0];
            step();
            note(S_P1, pv);
            step();
            note(S_SFR, pv);
            note(S_BIT, {7'h00, d[0]});
        end
        i_core.sfr_bit(A_TIMER_MODE, 3'h1, ~wv[7][1]);
        i_core.sfr_sel(A_TIMER_MODE);
        step();
        note(S_SFR, wv[7]);
        // reset again in mid-run
        @(negedge clk);
        nrst = 1'b0;
        @(negedge clk);
        nrst = 1'b1;
        note(S_SP, 8'h07);
        note(S_BANK, 8'h00);
        note(S_P0, 8'hff);
        step();
        results();
    end
endmodule // register_banks_and_sfr_map_tb
